/* verilog/bidc_pkg.sv */
// Package for the bridge I/O window and discard control register bank.
// Assumes a single core clock and a synchronous active-high reset.
package bidc_pkg;
  // Register byte offsets
  localparam logic [7:0] ADDR_IO_UPPER = 8'h30;  // I/O window upper bits
  localparam logic [7:0] ADDR_CAP_LIST = 8'h34;  // Capability list pointer
  localparam logic [7:0] ADDR_BCTRL    = 8'h3c;  // Bridge control and irq line
  localparam logic [7:0] ADDR_IRQ_STAT = 8'h40;  // Event status, write one to clear
  localparam logic [7:0] ADDR_IRQ_MASK = 8'h44;  // Event mask
  localparam logic [7:0] ADDR_AER_CTRL = 8'h48;  // Error reporting control
  // Reset values
  localparam logic [15:0] RST_IO_UPPER = 16'h0000;  // Base and limit extension reset
  localparam logic [7:0]  RST_CAP_LIST  = 8'ha0;    // Points at power management
  localparam logic [7:0]  RST_IRQ_LINE  = 8'hff;    // Interrupt line reset
  localparam logic [7:0]  SSID_CAP_LIST = 8'h60;    // Value software uses for SSID link
  // Field positions inside the register words
  localparam int IO_LIMIT_MSB = 31;  // Limit extension top bit
  localparam int IO_LIMIT_LSB = 16;  // Limit extension bottom bit
  localparam int IO_BASE_MSB  = 15;  // Base extension top bit
  localparam int IO_BASE_LSB  = 0;   // Base extension bottom bit
  localparam int BYTE_MSB     = 7;   // Pointer and irq line top bit
  localparam int BYTE_LSB     = 0;   // Pointer and irq line bottom bit
  localparam int BIT_EVENT    = 0;   // Event status and mask bit
  // Bridge control bit positions
  localparam int BIT_DISC_SERR = 27;  // Discard error message enable
  localparam int BIT_DISC_STAT = 26;  // Discard status
  localparam int BIT_DISC_SEL  = 25;  // Secondary discard length select
  // Error reporting control bit positions
  localparam int BIT_AER_FATAL = 0;  // Fatal severity select
  localparam int BIT_AER_MASK  = 1;  // Discard expired mask
  // Secondary discard timer lengths, in PCI clock enables
  localparam int DISC_LOG_LONG  = 15;
  localparam int DISC_LOG_SHORT = 10;
  localparam logic [15:0] DISC_LONG  = 16'h8000;
  localparam logic [15:0] DISC_SHORT = 16'h0400;
  // PCI clock divider: 125 MHz core to 33 MHz-ish PCI tick
  localparam logic [1:0] PCI_DIV_LAST = 2'h3;
endpackage

/* verilog/bidc_discard_timer.sv */
// Secondary discard timer for one delayed transaction.
// Assumes start and repeat come from same-clock bridge logic.
`timescale 1ns/1ps
module bidc_discard_timer (
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic tick,        // PCI clock enable
  input  wire logic short_sel,   // One selects short interval
  input  wire logic start,       // Completion reached head of queue
  input  wire logic repeat_seen, // Master repeated the request
  output logic      expired      // One-cycle discard pulse
);
  // All timer state
  typedef struct packed {
    logic        run;  // Timer active
    logic [15:0] cnt;  // Elapsed ticks
    logic        exp;  // Expiry pulse
  } bidc_tmr_t;
  bidc_tmr_t s_r, s_nxt;

  // Next-state logic
  always_comb
  begin
    logic [15:0] lim;
    lim = short_sel ? bidc_pkg::DISC_SHORT : bidc_pkg::DISC_LONG;
    s_nxt = s_r;
    s_nxt.exp = 1'b0;
    if (repeat_seen)
    begin
      s_nxt.run = 1'b0;  // Master came back in time
    end
    else if (start)
    begin
      s_nxt.run = 1'b1;
      s_nxt.cnt = 16'h0000;
    end
    else if (s_r.run && tick)
    begin
      if (s_r.cnt + 16'h0001 >= lim)
      begin
        s_nxt.run = 1'b0;  // Interval over, drop the transaction
        s_nxt.exp = 1'b1;
      end
      else
      begin
        s_nxt.cnt = s_r.cnt + 16'h0001;
      end
    end
  end

  // State register
  always_ff @(posedge clk)
  begin
    if (rst)
      s_r <= '0;
    else
      s_r <= s_nxt;
  end

  assign expired = s_r.exp;

  property p_exp_needs_run;
    @(posedge clk) disable iff (rst) s_r.exp |-> $past(s_r.run) && !s_r.run;
  endproperty
  a_exp_needs_run: assert property (p_exp_needs_run)
    else $error("discard expiry without running timer");
endmodule

/* verilog/bidc_regs.sv */
// Register bank for I/O window upper bits, capability pointer and
// discard timer controls. Assumes a single-cycle strobe register port.
`timescale 1ns/1ps
module bidc_regs (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic [7:0]  addr,          // Byte address
  input  wire logic [31:0] wdata,         // Write data
  input  wire logic        wr,            // Write strobe
  input  wire logic        rd,            // Read strobe
  output logic      [31:0] rdata,         // Read data, cycle after rd
  input  wire logic        pci_mode,      // Conventional PCI mode strap level
  input  wire logic        aer_supported, // Advanced error reporting present
  input  wire logic        dt_start,      // Completion at head of queue
  input  wire logic        dt_repeat,     // Master repeated request
  input  wire logic        dc_dropped,    // Delayed completion dropped
  output logic      [15:0] io_base_upper, // I/O base address bits 31:16
  output logic      [15:0] io_limit_upper,// I/O limit address bits 31:16
  output logic      [7:0]  capability_pointer,
  output logic             err_msg_valid, // One-cycle error message request
  output logic             err_msg_fatal, // Severity of that message
  output logic             irq            // Level interrupt
);
  // All register state
  typedef struct packed {
    logic [15:0] limit;     // Window limit extension
    logic [15:0] base;      // Window base extension
    logic [7:0]  cap;       // Capability pointer
    logic        serr_en;   // Discard error message enable
    logic        stat;      // Discard status
    logic        len_sel;   // Secondary discard length select
    logic [7:0]  irq_line;  // Interrupt line scratch
    logic        aer_fatal; // Fatal severity select
    logic        aer_mask;  // Discard expired mask
    logic        ist;       // Sticky discard event
    logic        imask;     // Event mask
    logic [31:0] rdata;     // Read data register
    logic        msg;       // Message pulse
    logic        msg_fatal; // Message severity
    logic [1:0]  div;       // PCI clock divider
  } bidc_reg_t;
  bidc_reg_t s_r, s_nxt;

  logic tick;     // PCI clock enable
  logic expired;  // Timer expiry pulse
  logic discard;  // Discard event

  assign tick = (s_r.div == bidc_pkg::PCI_DIV_LAST);

  // Discard timer
  bidc_discard_timer u_tmr (
    .clk         (clk),
    .rst         (rst),
    .tick        (tick),
    .short_sel   (s_r.len_sel),
    .start       (dt_start),
    .repeat_seen (dt_repeat),
    .expired     (expired)
  );

  assign discard = expired || dc_dropped;

  // Next-state logic: writes, reads, events
  always_comb
  begin
    logic send;
    send  = 1'b0;  // No message unless decided below
    s_nxt = s_r;
    s_nxt.div = s_r.div + 2'h1;
    s_nxt.msg = 1'b0;
    if (wr)
    begin
      unique case (addr)
        bidc_pkg::ADDR_IO_UPPER:
        begin
          s_nxt.limit = wdata[bidc_pkg::IO_LIMIT_MSB:bidc_pkg::IO_LIMIT_LSB];
          s_nxt.base  = wdata[bidc_pkg::IO_BASE_MSB:bidc_pkg::IO_BASE_LSB];
        end
        bidc_pkg::ADDR_CAP_LIST:
        begin
          s_nxt.cap = wdata[bidc_pkg::BYTE_MSB:bidc_pkg::BYTE_LSB];
        end
        bidc_pkg::ADDR_BCTRL:
        begin
          s_nxt.serr_en  = wdata[bidc_pkg::BIT_DISC_SERR];
          s_nxt.len_sel  = wdata[bidc_pkg::BIT_DISC_SEL];
          s_nxt.irq_line = wdata[bidc_pkg::BYTE_MSB:bidc_pkg::BYTE_LSB];
          if (wdata[bidc_pkg::BIT_DISC_STAT])
            s_nxt.stat = 1'b0;
        end
        bidc_pkg::ADDR_IRQ_STAT:
        begin
          if (wdata[bidc_pkg::BIT_EVENT])
            s_nxt.ist = 1'b0;
        end
        bidc_pkg::ADDR_IRQ_MASK:
        begin
          s_nxt.imask = wdata[bidc_pkg::BIT_EVENT];
        end
        bidc_pkg::ADDR_AER_CTRL:
        begin
          s_nxt.aer_fatal = wdata[bidc_pkg::BIT_AER_FATAL];
          s_nxt.aer_mask  = wdata[bidc_pkg::BIT_AER_MASK];
        end
        default:
        begin
          // Unmapped write ignored
        end
      endcase
    end
    // Events win over clears
    if (discard)
    begin
      s_nxt.stat = 1'b1;
      s_nxt.ist  = 1'b1;
    end
    // Message decision on a discard
    send = (pci_mode && s_r.serr_en)
        || (aer_supported && !s_r.aer_mask);
    if (discard && send)
    begin
      s_nxt.msg       = 1'b1;
      s_nxt.msg_fatal = aer_supported && s_r.aer_fatal;
    end
    // Read data, valid one cycle later
    s_nxt.rdata = 32'h0000_0000;
    if (rd)
    begin
      unique case (addr)
        bidc_pkg::ADDR_IO_UPPER:
          s_nxt.rdata = {s_r.limit, s_r.base};
        bidc_pkg::ADDR_CAP_LIST:
          s_nxt.rdata[bidc_pkg::BYTE_MSB:bidc_pkg::BYTE_LSB] = s_r.cap;
        bidc_pkg::ADDR_BCTRL:
        begin
          s_nxt.rdata[bidc_pkg::BIT_DISC_SERR] = s_r.serr_en;
          s_nxt.rdata[bidc_pkg::BIT_DISC_STAT] = s_r.stat;
          s_nxt.rdata[bidc_pkg::BIT_DISC_SEL]  = s_r.len_sel;
          s_nxt.rdata[bidc_pkg::BYTE_MSB:bidc_pkg::BYTE_LSB] = s_r.irq_line;
        end
        bidc_pkg::ADDR_IRQ_STAT:
          s_nxt.rdata[bidc_pkg::BIT_EVENT] = s_r.ist;
        bidc_pkg::ADDR_IRQ_MASK:
          s_nxt.rdata[bidc_pkg::BIT_EVENT] = s_r.imask;
        bidc_pkg::ADDR_AER_CTRL:
        begin
          s_nxt.rdata[bidc_pkg::BIT_AER_FATAL] = s_r.aer_fatal;
          s_nxt.rdata[bidc_pkg::BIT_AER_MASK]  = s_r.aer_mask;
        end
        default:
          s_nxt.rdata = 32'h0000_0000;  // Unmapped reads zero
      endcase
    end
  end

  // State register with reset values
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      s_r          <= '0;
      s_r.limit    <= bidc_pkg::RST_IO_UPPER;
      s_r.base     <= bidc_pkg::RST_IO_UPPER;
      s_r.cap      <= bidc_pkg::RST_CAP_LIST;
      s_r.irq_line <= bidc_pkg::RST_IRQ_LINE;
    end
    else
      s_r <= s_nxt;
  end

  // Outputs
  assign io_limit_upper     = s_r.limit;
  assign io_base_upper      = s_r.base;
  assign capability_pointer = s_r.cap;
  assign err_msg_valid      = s_r.msg;
  assign err_msg_fatal      = s_r.msg_fatal;
  assign irq                = s_r.ist && s_r.imask;
  assign rdata              = s_r.rdata;

  // Checks
  property p_limit_write;
    @(posedge clk) disable iff (rst)
      wr && addr == bidc_pkg::ADDR_IO_UPPER |=> io_limit_upper == $past(wdata[31:16]);
  endproperty
  a_limit_write: assert property (p_limit_write)
    else $error("limit extension not written");

  property p_base_write;
    @(posedge clk) disable iff (rst)
      wr && addr == bidc_pkg::ADDR_IO_UPPER |=> io_base_upper == $past(wdata[15:0]);
  endproperty
  a_base_write: assert property (p_base_write)
    else $error("base extension not written");

  property p_cap_reset;
    @(posedge clk) $fell(rst) |-> capability_pointer == bidc_pkg::RST_CAP_LIST;
  endproperty
  a_cap_reset: assert property (p_cap_reset)
    else $error("capability pointer reset wrong");

  property p_no_msg_disabled;
    @(posedge clk) disable iff (rst)
      discard && !(pci_mode && s_r.serr_en) && !(aer_supported && !s_r.aer_mask)
      |=> !err_msg_valid;
  endproperty
  a_no_msg_disabled: assert property (p_no_msg_disabled)
    else $error("message sent while disabled");

  property p_msg_enabled;
    @(posedge clk) disable iff (rst)
      discard && pci_mode && s_r.serr_en |=> err_msg_valid;
  endproperty
  a_msg_enabled: assert property (p_msg_enabled)
    else $error("enabled discard sent no message");

  property p_fatal_needs_aer;
    @(posedge clk) disable iff (rst) err_msg_valid && !aer_supported |-> !err_msg_fatal;
  endproperty
  a_fatal_needs_aer: assert property (p_fatal_needs_aer)
    else $error("fatal severity without error reporting");

  property p_aer_msg;
    @(posedge clk) disable iff (rst)
      discard && aer_supported && !s_r.aer_mask |=> err_msg_valid;
  endproperty
  a_aer_msg: assert property (p_aer_msg)
    else $error("unmasked discard sent no message");

  property p_stat_set;
    @(posedge clk) disable iff (rst) discard |=> s_r.stat;
  endproperty
  a_stat_set: assert property (p_stat_set)
    else $error("discard status not set");

  property p_stat_clear;
    @(posedge clk) disable iff (rst)
      wr && addr == bidc_pkg::ADDR_BCTRL && wdata[bidc_pkg::BIT_DISC_STAT] && !discard
      |=> !s_r.stat;
  endproperty
  a_stat_clear: assert property (p_stat_clear)
    else $error("status not cleared by write one");

  property p_window_reset;
    @(posedge clk) $fell(rst) |-> io_limit_upper == bidc_pkg::RST_IO_UPPER
      && io_base_upper == bidc_pkg::RST_IO_UPPER;
  endproperty
  a_window_reset: assert property (p_window_reset)
    else $error("window extension reset wrong");

  property p_window_hold;
    @(posedge clk) disable iff (rst)
      !(wr && addr == bidc_pkg::ADDR_IO_UPPER)
      |=> $stable(io_limit_upper) && $stable(io_base_upper);
  endproperty
  a_window_hold: assert property (p_window_hold)
    else $error("window extension changed without a write");

  property p_cap_write;
    @(posedge clk) disable iff (rst)
      wr && addr == bidc_pkg::ADDR_CAP_LIST |=> capability_pointer == $past(wdata[7:0]);
  endproperty
  a_cap_write: assert property (p_cap_write)
    else $error("capability pointer not written");

  property p_msg_needs_discard;
    @(posedge clk) disable iff (rst) err_msg_valid |-> $past(discard);
  endproperty
  a_msg_needs_discard: assert property (p_msg_needs_discard)
    else $error("message without a discard");

  property p_nonfatal_default;
    @(posedge clk) disable iff (rst)
      err_msg_valid && !$past(s_r.aer_fatal) |-> !err_msg_fatal;
  endproperty
  a_nonfatal_default: assert property (p_nonfatal_default)
    else $error("fatal severity without fatal select");

  property p_stat_keep;
    @(posedge clk) disable iff (rst)
      s_r.stat && wr && addr == bidc_pkg::ADDR_BCTRL && !wdata[bidc_pkg::BIT_DISC_STAT]
      |=> s_r.stat;
  endproperty
  a_stat_keep: assert property (p_stat_keep)
    else $error("status lost on write of zero");

  property p_set_beats_clear;
    @(posedge clk) disable iff (rst)
      discard && wr && addr == bidc_pkg::ADDR_BCTRL && wdata[bidc_pkg::BIT_DISC_STAT]
      |=> s_r.stat;
  endproperty
  a_set_beats_clear: assert property (p_set_beats_clear)
    else $error("clear beat a discard in the same cycle");

  property p_rd_idle;
    @(posedge clk) disable iff (rst) !rd |=> rdata == '0;
  endproperty
  a_rd_idle: assert property (p_rd_idle)
    else $error("read data not idle after a cycle without read");

  c_discard: cover property (@(posedge clk) disable iff (rst) expired);
  c_fatal:   cover property (@(posedge clk) disable iff (rst) err_msg_valid && err_msg_fatal);
  c_msg:     cover property (@(posedge clk) disable iff (rst) err_msg_valid);
  c_irq:     cover property (@(posedge clk) disable iff (rst) irq);
endmodule

/* testbench/bidc_host_model.sv */
// Host model: issues configuration accesses over the plain register port.
// Assumes one core clock; strobes last one cycle, read data the cycle after.
`timescale 1ns/1ps
module bidc_host_model (
  input  wire logic        clk,
  output logic      [7:0]  addr,
  output logic      [31:0] wdata,
  output logic             wr,
  output logic             rd,
  input  wire logic [31:0] rdata
);
  // Idle bus at time zero
  initial
  begin
    addr = 8'h00;
    wdata = 32'h0;
    wr = 1'b0;
    rd = 1'b0;
  end
  // One-cycle write, then the bus shows inverted junk once released
  task automatic cfg_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    addr <= ~a;
    wdata <= ~d;
  endtask
  // One-cycle read; data is taken once the answering edge has landed
  task automatic cfg_rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    addr <= ~a;
    #1 d = rdata;
  endtask
endmodule

/* testbench/bidc_regs_bench.sv */
// Self-checking bench for the I/O window and discard control bank.
// Assumes the host model drives the register port; bench drives events.
`timescale 1ns/1ps
module bidc_regs_bench;
  logic clk, rst, pci_mode, aer_supported, dt_start, dt_repeat, dc_dropped;
  logic [7:0]  addr, capability_pointer;
  logic [31:0] wdata, rdata, v, e;
  logic        wr, rd, err_msg_valid, err_msg_fatal, irq, send;
  logic [15:0] io_base_upper, io_limit_upper;
  int          fails, n_tests;
  // Core clock, 8 ns period
  initial
  begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  bidc_host_model host (.clk(clk), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata));
  bidc_regs dut (.clk(clk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .pci_mode(pci_mode), .aer_supported(aer_supported),
    .dt_start(dt_start), .dt_repeat(dt_repeat), .dc_dropped(dc_dropped),
    .io_base_upper(io_base_upper), .io_limit_upper(io_limit_upper),
    .capability_pointer(capability_pointer), .err_msg_valid(err_msg_valid),
    .err_msg_fatal(err_msg_fatal), .irq(irq));
  // Compare one value against its expectation
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string msg);
    n_tests++;
    if (seen !== exp)
    begin
      fails++;
      $display("unexpected at %0t: %s seen %h expected %h", $time, msg, seen, exp);
    end
  endtask
  // Print counts and verdict, then stop
  task automatic give_verdict;
    $display("Comparisons %0d, mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  // One-cycle event pulse on an input, checked just after the edge that takes it
  task automatic pulse(input int which);
    @(posedge clk);
    if (which == 0)
      dc_dropped <= 1'b1;
    else if (which == 1)
      dt_start <= 1'b1;
    else
      dt_repeat <= 1'b1;
    @(posedge clk);
    dc_dropped <= 1'b0;
    dt_start <= 1'b0;
    dt_repeat <= 1'b0;
    #1;
  endtask
  // Timer run: start, optional repeat, status checked around the short interval's expiry
  task automatic timer_run(input logic short_sel, input logic rep, input logic exp);
    host.cfg_wr(8'h3c, {6'h0, short_sel, 25'hff});
    pulse(1);
    repeat (100) @(posedge clk);
    if (rep) pulse(2);
    repeat (3900) @(posedge clk);
    host.cfg_rd(8'h3c, v);
    chk(v[26], 1'b0, "status early");
    repeat (300) @(posedge clk);
    host.cfg_rd(8'h3c, v);
    chk(v[26], exp, "status at expiry");
    host.cfg_wr(8'h3c, 32'h040000ff);
    pulse(2);
  endtask
  // Hang guard
  initial
  begin
    repeat (40000) @(posedge clk);
    fails++;
    give_verdict();
  end
  // Main sequence
  initial
  begin
    fails = 0;
    n_tests = 0;
    rst = 1'b1;
    {pci_mode, aer_supported, dt_start, dt_repeat, dc_dropped} = 5'h0;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    host.cfg_rd(8'h30, v);
    chk(v, 32'h0, "window reset");
    host.cfg_rd(8'h34, v);
    chk(v, 32'ha0, "pointer reset");
    host.cfg_rd(8'h3c, v);
    chk(v, 32'hff, "control reset");
    host.cfg_rd(8'h50, v);
    chk(v, 32'h0, "unmapped read");
    host.cfg_wr(8'h30, 32'h12345678);
    #1 chk({io_limit_upper, io_base_upper}, 32'h12345678, "window outputs");
    host.cfg_rd(8'h30, v);
    chk(v, 32'h12345678, "window readback");
    host.cfg_wr(8'h34, 32'hffffff60);
    host.cfg_rd(8'h34, v);
    chk(v, 32'h60, "pointer link");
    chk(capability_pointer, 8'h60, "pointer output");
    $display("Test registers done");
    // Every combination of mode, enable, support, mask and severity select
    for (int i = 0; i < 32; i++)
    begin
      e = (32'(i[1]) << 27) | 32'hff;
      host.cfg_wr(8'h3c, e);
      host.cfg_wr(8'h48, {30'h0, i[3], i[4]});
      host.cfg_wr(8'h44, {31'h0, i[0]});
      @(posedge clk);
      pci_mode <= i[0];
      aer_supported <= i[2];
      send = (i[0] & i[1]) | (i[2] & ~i[3]);
      pulse(0);
      chk(err_msg_valid, send, "message request");
      if (send)
        chk(err_msg_fatal, i[2] & i[4], "message severity");
      host.cfg_wr(8'h3c, e);
      host.cfg_rd(8'h3c, v);
      chk(v, e | 32'h04000000, "status kept");
      host.cfg_rd(8'h40, v);
      chk(v, 32'h1, "event status");
      chk(irq, i[0], "masked interrupt");
      host.cfg_wr(8'h3c, e | 32'h04000000);
      host.cfg_rd(8'h3c, v);
      chk(v, e, "status cleared");
      host.cfg_wr(8'h40, 32'h1);
      #1 chk(irq, 1'b0, "interrupt cleared");
    end
    $display("Test messages done");
    @(posedge clk);
    pci_mode <= 1'b0;
    aer_supported <= 1'b0;
    // A write-one clear and a discard in the same cycle: the discard wins
    fork
      host.cfg_wr(8'h3c, 32'h040000ff);
      pulse(0);
    join
    host.cfg_rd(8'h3c, v);
    chk(v, 32'h040000ff, "set beats clear");
    host.cfg_wr(8'h3c, 32'h040000ff);
    timer_run(1'b1, 1'b0, 1'b1);
    timer_run(1'b1, 1'b1, 1'b0);
    timer_run(1'b0, 1'b0, 1'b0);
    $display("Test timer done");
    give_verdict();
  end
endmodule
